// >>> rtl/can_rx_defines.svh
// Register offsets, field positions and constants of the receive FIFO and filter block
`ifndef CAN_RX_DEFINES_SVH
`define CAN_RX_DEFINES_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_MASTER_CTRL   12'h000
`define OFS_RX_FIFO_CTRL  12'h004
`define OFS_IRQ_ENABLE    12'h008
`define OFS_FILTER_MODE   12'h00C
`define OFS_FILTER_CFG    12'h010
`define OFS_MB_INDEX      12'h014
`define OFS_MB_DLC        12'h018
`define OFS_MB_ID         12'h01C
`define OFS_MB_DATA_LO    12'h020
`define OFS_MB_DATA_HI    12'h024
`define FILT_PAGE         4'h1
// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_LOCK          0
`define BIT_FULL          3
`define BIT_OVR           4
`define BIT_RELEASE       5
`define BIT_MSG_PENDING_IRQ_EN         1
`define BIT_FIFO_FULL_IRQ_EN          2
`define BIT_OVERRUN_IRQ_EN         3
`define POS_MODE_HI       8
`define CFG_STRIDE        4
`define CFG_POS_ACT       2
// ----------------------------------------
// Pending counts and filter coverage
// ----------------------------------------
`define CNT_EMPTY         2'h0
`define CNT_ONE           2'h1
`define CNT_FULL          2'h3
`define COV_32            32'hFFFFFFFE
`define COV_16            32'hFFF80000
`define COV_8             32'hFF000000
`define RANK_32           2'h3
`define RANK_16           2'h2
`define RANK_8            2'h1
`define SCALE_32          2'h3
`define SCALE_16          2'h2
`define SCALE_MIX         2'h1
`endif

// >>> rtl/can_rx_pkg.sv
// Types shared by the receive FIFO and filter block
package can_rx_pkg;
    typedef struct packed {
        logic [10:0] std_id;
        logic        rtr;
        logic        ide;
        logic [17:0] ext_id;
        logic [3:0]  dlc;
        logic [63:0] data;
    } rx_frame_type;

    typedef struct packed {
        rx_frame_type frame;
        logic [4:0]   match_idx;
    } rx_msg_type;
endpackage

// >>> rtl/can_rx_fifo_and_id_filter.sv
// Receive FIFO, acceptance filter banks and AHB-Lite register slave
// What this block does
// - Empty FIFO plus valid message: store it, show it, pending count becomes 01b.
// - Release frees output mailbox, decrements count, next stored message shows at once.
// - Unreleased: further messages take next free slot, count 10b then 11b.
// - Message arriving with three slots full is an overrun; overrun flag sets.
// - Overrun without lock: newest slot is overwritten by incoming message.
// - Overrun with lock: incoming message discarded, three oldest kept.
// - Count going 00b to 01b raises interrupt when pending enable set.
// - Third message stored sets full flag; interrupt when full enable set.
// - Overrun flag raises interrupt when overrun enable set.
// - Six scalable filter banks, each eight 8-bit registers.
// - 32-bit scale covers whole identifier; 16-bit covers standard id, RTR, IDE.
// - 8-bit filters compare standard id bits 10..3; mixed gives one 16 two 8.
// - Scale field: 3 one 32-bit, 2 two 16-bit, 1 mixed, 0 four 8-bit.
// - Mask mode: set mask bits must match, cleared bits are don't care.
// - List mode: mask register is second identifier; covered bits must equal one.
// - Low mode bit rules low two byte pairs, high mode bit the upper ones; 32-bit scale uses the low bit only.
// - Matching filter index stored with each accepted message.
// - List beats mask; wider coverage beats narrower.
// - Equal class: lowest filter number wins.
// - Identifier matching no active filter is dropped silently.
// - Only error-free frames that passed filtering are stored.
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "can_rx_defines.svh"

module can_rx_fifo_and_id_filter
    import can_rx_pkg::*;
#(
    parameter int NUM_BANKS = 6
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic              hresp,
    output logic [31:0]       hrdata,
    input  wire logic         frame_valid,
    input  wire logic         frame_ok,
    input  wire rx_frame_type frame_in,
    output logic              rx_irq
);
    if (NUM_BANKS < 1 || NUM_BANKS > 6) begin : g_chk
        $error("NUM_BANKS must be 1 to 6");
    end

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic             lock_q;
    logic [2:0]       irq_en_q;
    logic [NUM_BANKS-1:0] mode_lo_q;
    logic [NUM_BANKS-1:0] mode_hi_q;
    logic [1:0]       scale_q [NUM_BANKS];
    logic [NUM_BANKS-1:0] active_q;
    logic [7:0]       filt_q [NUM_BANKS][8];
    logic [1:0]       count_q;
    logic [1:0]       rd_q;
    logic             full_q;
    logic             ovr_q;
    rx_msg_type       slot_q [3];
    rx_msg_type       mbox_q;

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic        wr_pend_q;
    logic        rd_pend_q;
    logic [11:0] addr_q;
    logic        take;
    logic        wr_now;

    assign take      = hsel & htrans[1] & hready;
    assign wr_now    = wr_pend_q;
    assign hreadyout = ~rd_pend_q;
    assign hresp     = 1'b0;

    // One wait state on reads so the data always come from a flip-flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 12'h000;
        end else begin
            wr_pend_q <= take & hwrite;
            rd_pend_q <= take & ~hwrite;
            if (take) begin
                addr_q <= haddr[11:0];
            end
        end
    end

    logic       filt_hit;
    logic [2:0] filt_bank;
    logic [2:0] filt_reg;
    assign filt_hit  = (addr_q[11:8] == `FILT_PAGE) && (addr_q[7:5] < NUM_BANKS[2:0]);
    assign filt_bank = addr_q[7:5];
    assign filt_reg  = addr_q[4:2];

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        if (filt_hit) begin
            rd_mux[7:0] = filt_q[filt_bank][filt_reg];
        end else begin
            case (addr_q)
                `OFS_MASTER_CTRL:  rd_mux[`BIT_LOCK] = lock_q;
                `OFS_RX_FIFO_CTRL: rd_mux = {26'h0000000, 1'b0, ovr_q, full_q, 1'b0, count_q};
                `OFS_IRQ_ENABLE:   rd_mux[`BIT_OVERRUN_IRQ_EN:`BIT_MSG_PENDING_IRQ_EN] = irq_en_q;
                `OFS_FILTER_MODE: begin
                    rd_mux[NUM_BANKS-1:0] = mode_lo_q;
                    rd_mux[`POS_MODE_HI +: NUM_BANKS] = mode_hi_q;
                end
                `OFS_FILTER_CFG: begin
                    for (int b = 0; b < NUM_BANKS; b++) begin
                        rd_mux[b*`CFG_STRIDE +: 2] = scale_q[b];
                        rd_mux[b*`CFG_STRIDE + `CFG_POS_ACT] = active_q[b];
                    end
                end
                `OFS_MB_INDEX:   rd_mux[4:0] = mbox_q.match_idx;
                `OFS_MB_DLC:     rd_mux[3:0] = mbox_q.frame.dlc;
                `OFS_MB_ID:      rd_mux = {mbox_q.frame.std_id, mbox_q.frame.rtr, mbox_q.frame.ide,
                                           mbox_q.frame.ext_id, 1'b0};
                `OFS_MB_DATA_LO: rd_mux = mbox_q.frame.data[31:0];
                `OFS_MB_DATA_HI: rd_mux = mbox_q.frame.data[63:32];
                default:         rd_mux = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (rd_pend_q) begin
            hrdata <= rd_mux;
        end
    end

    // ----------------------------------------
    // Control and filter registers
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_q    <= 1'b0;
            irq_en_q  <= 3'h0;
            mode_lo_q <= '0;
            mode_hi_q <= '0;
            active_q  <= '0;
            for (int b = 0; b < NUM_BANKS; b++) begin
                scale_q[b] <= 2'h0;
            end
        end else if (wr_now && !filt_hit) begin
            case (addr_q)
                `OFS_MASTER_CTRL: lock_q   <= hwdata[`BIT_LOCK];
                `OFS_IRQ_ENABLE:  irq_en_q <= hwdata[`BIT_OVERRUN_IRQ_EN:`BIT_MSG_PENDING_IRQ_EN];
                `OFS_FILTER_MODE: begin
                    mode_lo_q <= hwdata[NUM_BANKS-1:0];
                    mode_hi_q <= hwdata[`POS_MODE_HI +: NUM_BANKS];
                end
                `OFS_FILTER_CFG: begin
                    for (int b = 0; b < NUM_BANKS; b++) begin
                        scale_q[b]  <= hwdata[b*`CFG_STRIDE +: 2];
                        active_q[b] <= hwdata[b*`CFG_STRIDE + `CFG_POS_ACT];
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                for (int r = 0; r < 8; r++) begin
                    filt_q[b][r] <= 8'h00;
                end
            end
        end else if (wr_now && filt_hit) begin
            filt_q[filt_bank][filt_reg] <= hwdata[7:0];
        end
    end

    // ----------------------------------------
    // Acceptance filtering
    // ----------------------------------------
    logic [31:0] idv;
    logic        best_hit;
    logic [2:0]  best_rank;
    logic [4:0]  best_idx;
    assign idv = {frame_in.std_id, frame_in.rtr, frame_in.ide, frame_in.ext_id, 1'b0};

    // Indices are bank*4+slot; a higher rank wins, equal ranks keep the first (lowest) index
    always_comb begin
        logic [31:0] f;
        logic [31:0] m;
        logic [31:0] cov;
        logic        lst;
        logic [1:0]  cr;
        logic        pres;
        logic        hit;
        f = 32'h0;
        m = 32'h0;
        cov = 32'h0;
        lst = 1'b0;
        cr = 2'h0;
        pres = 1'b0;
        hit = 1'b0;
        best_hit = 1'b0;
        best_rank = 3'h0;
        best_idx = 5'h00;
        for (int b = 0; b < NUM_BANKS; b++) begin
            for (int s = 0; s < 4; s++) begin
                pres = 1'b1;
                unique case (scale_q[b])
                    `SCALE_32: begin
                        f = {filt_q[b][0], filt_q[b][1], filt_q[b][2], filt_q[b][3]};
                        m = {filt_q[b][4], filt_q[b][5], filt_q[b][6], filt_q[b][7]};
                        cov = `COV_32;
                        cr = `RANK_32;
                        lst = mode_lo_q[b];
                        pres = (s == 0);
                    end
                    `SCALE_16: begin
                        f = {filt_q[b][s*4], filt_q[b][s*4+1], 16'h0000};
                        m = {filt_q[b][s*4+2], filt_q[b][s*4+3], 16'h0000};
                        cov = `COV_16;
                        cr = `RANK_16;
                        lst = (s == 0) ? mode_lo_q[b] : mode_hi_q[b];
                        pres = (s < 2);
                    end
                    `SCALE_MIX: begin
                        if (s == 0) begin
                            f = {filt_q[b][0], filt_q[b][1], 16'h0000};
                            m = {filt_q[b][2], filt_q[b][3], 16'h0000};
                            cov = `COV_16;
                            cr = `RANK_16;
                            lst = mode_lo_q[b];
                        end else begin
                            f = {filt_q[b][s*2], 24'h000000};
                            m = {filt_q[b][s*2+1], 24'h000000};
                            cov = `COV_8;
                            cr = `RANK_8;
                            lst = mode_hi_q[b];
                        end
                        pres = (s != 1);
                    end
                    default: begin
                        f = {filt_q[b][s*2], 24'h000000};
                        m = {filt_q[b][s*2+1], 24'h000000};
                        cov = `COV_8;
                        cr = `RANK_8;
                        lst = (s < 2) ? mode_lo_q[b] : mode_hi_q[b];
                    end
                endcase
                if (lst) begin
                    hit = (((idv ^ f) & cov) == 32'h0) || (((idv ^ m) & cov) == 32'h0);
                end else begin
                    hit = ((idv ^ f) & m & cov) == 32'h0;
                end
                if (pres && active_q[b] && hit && (!best_hit || {lst, cr} > best_rank)) begin
                    best_hit = 1'b1;
                    best_rank = {lst, cr};
                    best_idx = 5'(b * 4 + s);
                end
            end
        end
    end

    // ----------------------------------------
    // Receive FIFO
    // ----------------------------------------
    logic       push;
    logic       rel;
    logic [1:0] cnt1;
    logic [1:0] rd1;
    logic [1:0] wr_slot;
    logic [1:0] last_slot;
    logic       ovr_ev;
    logic       full_ev;
    rx_msg_type msg_in;

    function automatic logic [1:0] wrap3(input logic [2:0] v);
        wrap3 = (v >= 3'd3) ? 2'(v - 3'd3) : v[1:0];
    endfunction

    assign push      = frame_valid & frame_ok & best_hit;
    assign rel       = wr_now && !filt_hit && (addr_q == `OFS_RX_FIFO_CTRL)
                       && hwdata[`BIT_RELEASE] && (count_q != `CNT_EMPTY);
    assign cnt1      = rel ? 2'(count_q - 2'h1) : count_q;
    assign rd1       = rel ? wrap3({1'b0, rd_q} + 3'd1) : rd_q;
    assign wr_slot   = wrap3({1'b0, rd1} + {1'b0, cnt1});
    assign last_slot = wrap3({1'b0, rd1} + 3'd2);
    assign ovr_ev    = push && (cnt1 == `CNT_FULL);
    assign full_ev   = push && (cnt1 == 2'h2);
    assign msg_in    = '{frame: frame_in, match_idx: best_idx};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q <= `CNT_EMPTY;
            rd_q    <= 2'h0;
        end else begin
            rd_q <= rd1;
            if (push && !ovr_ev) begin
                count_q <= 2'(cnt1 + 2'h1);
            end else begin
                count_q <= cnt1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 3; i++) begin
                slot_q[i] <= '0;
            end
        end else if (push && !ovr_ev) begin
            slot_q[wr_slot] <= msg_in;
        end else if (ovr_ev && !lock_q) begin
            slot_q[last_slot] <= msg_in;
        end
        // Locked overrun writes nothing, keeping the three oldest
    end

    // Output mailbox follows the head slot, including a message pushed into an empty FIFO
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mbox_q <= '0;
        end else if (push && cnt1 == `CNT_EMPTY) begin
            mbox_q <= msg_in;
        end else if (ovr_ev && !lock_q && count_q == `CNT_FULL && rel) begin
            mbox_q <= slot_q[rd1];
        end else begin
            mbox_q <= slot_q[rd1];
        end
    end

    // Hardware set wins over a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            full_q <= 1'b0;
            ovr_q  <= 1'b0;
        end else begin
            if (full_ev) begin
                full_q <= 1'b1;
            end else if (rel) begin
                full_q <= 1'b0;
            end
            if (ovr_ev) begin
                ovr_q <= 1'b1;
            end else if (wr_now && !filt_hit && addr_q == `OFS_RX_FIFO_CTRL && hwdata[`BIT_OVR]) begin
                ovr_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Reception interrupt, a level held while its cause stands
    // ----------------------------------------
    assign rx_irq = (irq_en_q[0] & (count_q != `CNT_EMPTY))
                  | (irq_en_q[1] & full_q)
                  | (irq_en_q[2] & ovr_q);
endmodule

`default_nettype wire

// >>> verification/can_rx_monitor.sv
// Port-level checker for the receive FIFO and filter block
`timescale 1ns/100ps
`default_nettype none
module can_rx_monitor
    import can_rx_pkg::*;
#(
    parameter int NUM_BANKS = 6
) (
    input wire logic         hclk,
    input wire logic         hresetn,
    input wire logic         hsel,
    input wire logic [31:0]  haddr,
    input wire logic [1:0]   htrans,
    input wire logic         hwrite,
    input wire logic [2:0]   hsize,
    input wire logic [31:0]  hwdata,
    input wire logic         hready,
    input wire logic         hreadyout,
    input wire logic         hresp,
    input wire logic [31:0]  hrdata,
    input wire logic         frame_valid,
    input wire logic         frame_ok,
    input wire rx_frame_type frame_in,
    input wire logic         rx_irq
);
    logic rd_take;
    logic wr_take;
    logic wr_dp_q;
    assign rd_take = hsel && htrans[1] && hready && !hwrite;
    assign wr_take = hsel && htrans[1] && hready && hwrite;
    // Register writes land one edge after the data phase, so irq changes may trail it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_dp_q <= 1'b0;
        end else begin
            wr_dp_q <= wr_take;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("slave answered with an error response");
    read_wait_a: assert property (rd_take |=> !hreadyout ##1 hreadyout)
        else $error("read did not take exactly one wait state");
    write_nowait_a: assert property (wr_take |=> hreadyout)
        else $error("write was stalled");
    wait_single_a: assert property (!hreadyout |=> hreadyout)
        else $error("wait state longer than one cycle");
    rdata_hold_a: assert property (!$stable(hrdata) |-> $past(!hreadyout))
        else $error("read data changed outside a read");
    irq_rise_cause_a: assert property ($rose(rx_irq) |-> $past(frame_valid && frame_ok) || $past(wr_dp_q))
        else $error("interrupt rose without a frame or a write");
    irq_fall_cause_a: assert property ($fell(rx_irq) |-> $past(wr_dp_q))
        else $error("interrupt fell without a register write");
    bad_frame_quiet_a: assert property (frame_valid && !frame_ok && !wr_dp_q |=> $stable(rx_irq))
        else $error("errored frame changed the interrupt");
    read_seen_c: cover property (rd_take);
    irq_rise_c: cover property ($rose(rx_irq));
    bad_frame_c: cover property (frame_valid && !frame_ok);
endmodule
bind can_rx_fifo_and_id_filter can_rx_monitor #(.NUM_BANKS(NUM_BANKS)) i_mon (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .frame_valid(frame_valid), .frame_ok(frame_ok),
    .frame_in(frame_in), .rx_irq(rx_irq)
);
`default_nettype wire

// >>> verification/rx_core_model.sv
// Behavioural protocol core that hands received frames to the block
`timescale 1ns/100ps
`default_nettype none
module rx_core_model
    import can_rx_pkg::*;
(
    input  wire logic    hclk,
    output logic         frame_valid,
    output logic         frame_ok,
    output rx_frame_type frame_in
);
    initial begin
        frame_valid = 1'b0;
        frame_ok    = 1'b0;
        frame_in    = '0;
    end
    // Fields mean nothing outside the strobe, so they are scrambled afterwards
    task automatic send(input logic [10:0] id, input logic ok);
        @(posedge hclk);
        frame_valid <= 1'b1;
        frame_ok    <= ok;
        frame_in    <= '{std_id: id, rtr: 1'b0, ide: 1'b0, ext_id: 18'h0, dlc: 4'h8, data: {8{id[7:0]}}};
        @(posedge hclk);
        frame_valid <= 1'b0;
        frame_ok    <= 1'b0;
        frame_in    <= ~frame_in;
    endtask
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the receive FIFO and filter block
`timescale 1ns/100ps
`default_nettype none
`include "can_rx_defines.svh"
module tb_top;
    import can_rx_pkg::*;
    logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic         frame_valid, frame_ok, rx_irq;
    logic [31:0]  haddr, hwdata, hrdata, rd;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    rx_frame_type frame_in;
    int           bad_count, n_checks;
    localparam logic [31:0] A_CTRL = {20'h0, `OFS_MASTER_CTRL};
    localparam logic [31:0] A_FIFO = {20'h0, `OFS_RX_FIFO_CTRL};
    localparam logic [31:0] A_IRQ  = {20'h0, `OFS_IRQ_ENABLE};
    localparam logic [31:0] A_MODE = {20'h0, `OFS_FILTER_MODE};
    localparam logic [31:0] A_CFG  = {20'h0, `OFS_FILTER_CFG};
    localparam logic [31:0] A_IDX  = {20'h0, `OFS_MB_INDEX};
    localparam logic [31:0] A_ID   = {20'h0, `OFS_MB_ID};
    can_rx_fifo_and_id_filter #(.NUM_BANKS(6)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .frame_valid(frame_valid),
        .frame_ok(frame_ok), .frame_in(frame_in), .rx_irq(rx_irq)
    );
    rx_core_model i_core (.hclk(hclk), .frame_valid(frame_valid), .frame_ok(frame_ok), .frame_in(frame_in));
    always #20 hclk = ~hclk;
    // ----------------------------------------
    // Bus and compare helpers
    // ----------------------------------------
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask
    // Interrupt is combinational from registers, so look mid-cycle once the edge has settled
    task automatic ichk(input string nm, input logic exp);
        @(negedge hclk);
        chk(nm, {31'h0, exp}, {31'h0, rx_irq});
    endtask
    task automatic mbx(input logic [10:0] id, input logic [31:0] idx);
        rchk("mailbox_id", A_ID, {id, 21'h0});
        rchk("match_index", A_IDX, idx);
    endtask
    task automatic close_out;
        if (bad_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge hclk);
        bad_count++;
        close_out;
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        bad_count = 0;
        n_checks = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rchk("fifo_reset", A_FIFO, 32'h0);
        bus(1'b1, 32'h0F0, 32'hFFFFFFFF);
        rchk("unmapped", 32'h0F0, 32'h0);
        bus(1'b1, 32'h1C0, 32'h5A);
        rchk("bank6_reg0", 32'h1C0, 32'h0);
        // Banks stay inactive until identifiers are in place
        bus(1'b1, A_IRQ, 32'h2);
        bus(1'b1, A_MODE, 32'h2);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 32'h120 + 4 * i, i[0] ? 32'h60 : 32'h24);
        end
        rchk("bank1_reg1", 32'h124, 32'h60);
        bus(1'b1, A_CFG, 32'h767);
        i_core.send(11'h123, 1'b1);
        ichk("irq_first", 1'b1);
        rchk("count_one", A_FIFO, 32'h1);
        mbx(11'h123, 32'h4);
        i_core.send(11'h2AA, 1'b0);
        rchk("bad_frame", A_FIFO, 32'h1);
        i_core.send(11'h055, 1'b1);
        i_core.send(11'h066, 1'b1);
        rchk("count_three", A_FIFO, 32'hB);
        i_core.send(11'h077, 1'b1);
        rchk("overrun", A_FIFO, 32'h1B);
        bus(1'b1, A_FIFO, 32'h20);
        rchk("released", A_FIFO, 32'h12);
        mbx(11'h055, 32'h0);
        bus(1'b1, A_FIFO, 32'h20);
        mbx(11'h077, 32'h0);
        bus(1'b1, A_FIFO, 32'h30);
        rchk("drained", A_FIFO, 32'h0);
        chk("irq_drained", 32'h0, {31'h0, rx_irq});
        bus(1'b1, A_CTRL, 32'h1);
        bus(1'b1, A_IRQ, 32'h4);
        for (int i = 1; i < 4; i++) begin
            i_core.send(11'h100 + 11'(i), 1'b1);
        end
        ichk("irq_full", 1'b1);
        bus(1'b1, A_IRQ, 32'h8);
        ichk("irq_no_ovr", 1'b0);
        i_core.send(11'h104, 1'b1);
        ichk("irq_ovr", 1'b1);
        bus(1'b1, A_FIFO, 32'h20);
        bus(1'b1, A_FIFO, 32'h20);
        mbx(11'h103, 32'h0);
        bus(1'b1, A_CFG, 32'h0);
        bus(1'b1, A_FIFO, 32'h30);
        i_core.send(11'h123, 1'b1);
        rchk("no_match", A_FIFO, 32'h0);
        bus(1'b1, A_MODE, 32'h802);
        bus(1'b1, 32'h178, 32'h20);
        bus(1'b1, A_CFG, 32'h5000);
        i_core.send(11'h100, 1'b1);
        mbx(11'h100, 32'hF);
        close_out;
    end
endmodule
`default_nettype wire
